// ==== rtl/dpm_ctl.sv ====
// profile modulation, amplitude ramp pin and power-down control
`timescale 1ns/1ps
module dpm_ctl
   import dpm_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 reset_n_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   input  wire logic [4:0]           reg_addr_in,
   input  wire logic [31:0]          reg_wdata_in,
   input  wire logic [1:0]           reg_chan_en_in,
   input  wire logic [3:0]           profile_pin_in,
   input  wire logic                 ext_powerdown_pin_in,
   input  wire logic [1:0]           ramp_serial_in,
   output logic      [31:0]          reg_rdata_out,
   output logic      [2*FREQ_W-1:0]  chan_freq_out,
   output logic      [2*PHASE_W-1:0] chan_phase_out,
   output logic      [2*AMPL_W-1:0]  chan_ampl_out,
   output logic      [1:0]           chan_mod_active_out,
   output logic      [1:0]           chan_ramp_en_out,
   output logic      [1:0]           chan_ramp_down_out,
   output logic      [3:0]           chan_dac_shift_out,
   output logic      [1:0]           chan_digital_pd_out,
   output logic      [1:0]           chan_dac_digital_pd_out,
   output logic      [1:0]           chan_dac_analog_pd_out,
   output logic                      clk_input_pd_out,
   output logic                      pll_pd_out,
   output logic                      osc_pd_out,
   output logic                      serial_single_bit_out
);
   logic [FUNC_W-1:0]  global_function_reg_ff;
   logic [FUNC_W-1:0]  channel_function_reg_ff [NUM_CH];
   logic [FREQ_W-1:0]  chan_freq_word0_ff      [NUM_CH];
   logic [PHASE_W-1:0] chan_phase_word0_ff     [NUM_CH];
   logic [AMPL_W-1:0]  chan_ampl_word0_ff      [NUM_CH];
   logic [31:0]        chan_profile_ff         [NUM_CH][1:15];
   logic [3:0]         pin_sync;
   logic [1:0]         serial_sync;
   logic               pd_sync;
   logic [3:0]         word_idx_ff             [NUM_CH];
   logic [1:0]         word_use_ff;
   logic [1:0]         ramp_dir_ff;
   logic [1:0]         nxt_use;
   logic [1:0]         nxt_dir;
   logic [3:0]         nxt_idx                 [NUM_CH];
   logic               rd_ch;

   // full-scale code to attenuation shift
   function automatic logic [1:0] dac_shift(input logic [1:0] code);
      unique case (code)
         2'h3:    dac_shift = 2'h0;
         2'h1:    dac_shift = 2'h1;
         2'h2:    dac_shift = 2'h2;
         default: dac_shift = 2'h3;
      endcase
   endfunction : dac_shift

   // fetch a 32-bit word by index, word 0 being the dedicated register
   function automatic logic [31:0] pick_word(
      input logic [3:0]  idx,
      input logic [31:0] base,
      input logic [31:0] prof [1:15]
   );
      if (idx == 4'h0)
         pick_word = base;
      else
         pick_word = prof[idx];
   endfunction : pick_word

   dpm_pin_sync #(
      .WIDTH (7)
   ) u_sync (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .pins_in    ({ext_powerdown_pin_in, ramp_serial_in, profile_pin_in}),
      .pins_out   ({pd_sync, serial_sync, pin_sync})
   );

   // global function register
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         global_function_reg_ff <= GLOBAL_FUNC_RST;
      else if (reg_wr_in && reg_addr_in == OFS_GLOBAL_FUNC)
         global_function_reg_ff <= reg_wdata_in[FUNC_W-1:0];
   end

   // per-channel registers, written where the channel enable is set
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            channel_function_reg_ff[c] <= CHAN_FUNC_RST;
            chan_freq_word0_ff[c]      <= '0;
            chan_phase_word0_ff[c]     <= '0;
            chan_ampl_word0_ff[c]      <= '0;
            for (int w = 1; w < 16; w++)
               chan_profile_ff[c][w] <= '0;
         end
      end
      else if (reg_wr_in)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (reg_chan_en_in[c])
            begin
               unique case (reg_addr_in)
                  OFS_CHAN_FUNC:
                     channel_function_reg_ff[c] <= reg_wdata_in[FUNC_W-1:0];
                  OFS_FREQ_WORD0:
                     chan_freq_word0_ff[c] <= reg_wdata_in;
                  OFS_PHASE_WORD0:
                     chan_phase_word0_ff[c] <= reg_wdata_in[PHASE_W-1:0];
                  OFS_AMPL_WORD0:
                     chan_ampl_word0_ff[c] <= reg_wdata_in[AMPL_W-1:0];
                  default:
                  begin
                     if (reg_addr_in >= OFS_PROFILE_1 &&
                         reg_addr_in <= OFS_PROFILE_15)
                        chan_profile_ff[c][4'(reg_addr_in - OFS_PROFILE_1)
                           + 4'h1] <= reg_wdata_in;
                  end
               endcase
            end
         end
      end
   end

   // read port: channel 0 answers when enabled, else channel 1
   assign rd_ch = ~reg_chan_en_in[0];

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         reg_rdata_out <= '0;
      else if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            OFS_GLOBAL_FUNC:
               reg_rdata_out <= {8'h00, global_function_reg_ff};
            OFS_CHAN_FUNC:
               reg_rdata_out <= {8'h00, channel_function_reg_ff[rd_ch]};
            OFS_FREQ_WORD0:
               reg_rdata_out <= chan_freq_word0_ff[rd_ch];
            OFS_PHASE_WORD0:
               reg_rdata_out <= {18'h0, chan_phase_word0_ff[rd_ch]};
            OFS_AMPL_WORD0:
               reg_rdata_out <= {22'h0, chan_ampl_word0_ff[rd_ch]};
            default:
            begin
               if (reg_addr_in >= OFS_PROFILE_1 &&
                   reg_addr_in <= OFS_PROFILE_15)
                  reg_rdata_out <= chan_profile_ff[rd_ch]
                     [4'(reg_addr_in - OFS_PROFILE_1) + 4'h1];
               else
                  reg_rdata_out <= '0;
            end
         endcase
      end
   end

   // word index, use and ramp direction from synchronised pins
   always_comb
   begin
      logic [2:0] profile_pin_config;
      logic [1:0] sel;
      logic       tgt;
      profile_pin_config = global_function_reg_ff[G_PPC_HI:G_PPC_LO];
      sel = profile_pin_config[1:0];
      tgt = (sel == PPC_SEL_CH1);
      nxt_use = 2'h0;
      nxt_dir = 2'h0;
      for (int c = 0; c < NUM_CH; c++)
         nxt_idx[c] = 4'h0;
      unique case (dpm_ramp_sel_t'(
         global_function_reg_ff[G_RAMP_HI:G_RAMP_LO]))
         RAMP_PINS_23:
         begin
            if (profile_pin_config == PPC_FOUR_LVL)
            begin
               nxt_idx[0] = {3'h0, pin_sync[0]};
               nxt_idx[1] = {3'h0, pin_sync[1]};
               nxt_use    = 2'h3;
            end
            nxt_dir = pin_sync[3:2];
         end
         RAMP_PIN_3:
         begin
            if (sel == PPC_SEL_CH0 || sel == PPC_SEL_CH1)
            begin
               nxt_idx[tgt] = {1'b0, pin_sync[0], pin_sync[1],
                               pin_sync[2]};
               nxt_use[tgt] = 1'b1;
               nxt_dir[tgt] = pin_sync[3];
            end
         end
         default:
         begin
            if (global_function_reg_ff[G_RAMP_HI:G_RAMP_LO] == RAMP_SERIAL)
               nxt_dir = serial_sync;
            unique case (dpm_mod_level_t'(
               global_function_reg_ff[G_LEVEL_HI:G_LEVEL_LO]))
               LVL_TWO:
               begin
                  nxt_idx[0] = {3'h0, pin_sync[2]};
                  nxt_idx[1] = {3'h0, pin_sync[3]};
                  nxt_use    = 2'h3;
               end
               LVL_FOUR:
               begin
                  if (profile_pin_config == PPC_FOUR_LVL)
                  begin
                     nxt_idx[0] = {2'h0, pin_sync[0], pin_sync[1]};
                     nxt_idx[1] = {2'h0, pin_sync[2], pin_sync[3]};
                     nxt_use    = 2'h3;
                  end
               end
               LVL_EIGHT:
               begin
                  if (sel == PPC_SEL_CH0 || sel == PPC_SEL_CH1)
                  begin
                     nxt_idx[tgt] = {1'b0, pin_sync[0], pin_sync[1],
                                     pin_sync[2]};
                     nxt_use[tgt] = 1'b1;
                  end
               end
               LVL_SIXTEEN:
               begin
                  if (sel == PPC_SEL_CH0 || sel == PPC_SEL_CH1)
                  begin
                     nxt_idx[tgt] = {pin_sync[0], pin_sync[1],
                                     pin_sync[2], pin_sync[3]};
                     nxt_use[tgt] = 1'b1;
                  end
               end
            endcase
         end
      endcase
   end

   // pin decode stage, common to both channels
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         word_use_ff <= 2'h0;
         ramp_dir_ff <= 2'h0;
         for (int c = 0; c < NUM_CH; c++)
            word_idx_ff[c] <= 4'h0;
      end
      else
      begin
         word_use_ff <= nxt_use;
         ramp_dir_ff <= nxt_dir;
         for (int c = 0; c < NUM_CH; c++)
            word_idx_ff[c] <= nxt_idx[c];
      end
   end

   // per-channel word outputs and ramp control
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         chan_freq_out       <= '0;
         chan_phase_out      <= '0;
         chan_ampl_out       <= '0;
         chan_mod_active_out <= 2'h0;
         chan_ramp_en_out    <= 2'h0;
         chan_ramp_down_out  <= 2'h0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            logic [1:0]  mt;
            logic        act;
            logic [31:0] w;
            mt  = channel_function_reg_ff[c][C_MOD_HI:C_MOD_LO];
            act = word_use_ff[c] && mt != MOD_NONE &&
                  !channel_function_reg_ff[c][C_LIN_SWEEP];
            chan_mod_active_out[c] <= act;
            chan_freq_out[c*FREQ_W +: FREQ_W] <= chan_freq_word0_ff[c];
            chan_phase_out[c*PHASE_W +: PHASE_W] <= chan_phase_word0_ff[c];
            chan_ampl_out[c*AMPL_W +: AMPL_W] <= chan_ampl_word0_ff[c];
            unique case (dpm_mod_type_t'(mt))
               MOD_FREQ:
               begin
                  w = pick_word(word_idx_ff[c], chan_freq_word0_ff[c],
                                chan_profile_ff[c]);
                  if (act)
                     chan_freq_out[c*FREQ_W +: FREQ_W] <= w;
               end
               MOD_PHASE:
               begin
                  w = pick_word(word_idx_ff[c],
                                {chan_phase_word0_ff[c], 18'h0},
                                chan_profile_ff[c]);
                  if (act)
                     chan_phase_out[c*PHASE_W +: PHASE_W] <=
                        w[31:32-PHASE_W];
               end
               MOD_AMPL:
               begin
                  w = pick_word(word_idx_ff[c],
                                {chan_ampl_word0_ff[c], 22'h0},
                                chan_profile_ff[c]);
                  if (act)
                     chan_ampl_out[c*AMPL_W +: AMPL_W] <=
                        w[31:32-AMPL_W];
               end
               default:
                  w = '0;
            endcase
            // ramp never with amplitude modulation or amplitude sweep
            chan_ramp_en_out[c] <=
               global_function_reg_ff[G_RAMP_HI:G_RAMP_LO] != RAMP_OFF &&
               mt != MOD_AMPL &&
               !(global_function_reg_ff[G_RAMP_HI:G_RAMP_LO] == RAMP_PIN_3
                 && !word_use_ff[c]) &&
               !channel_function_reg_ff[c][C_LIN_SWEEP];
            chan_ramp_down_out[c] <= ramp_dir_ff[c];
         end
      end
   end

   // dac full-scale scaling
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         chan_dac_shift_out <= 4'h0;
      else
         for (int c = 0; c < NUM_CH; c++)
            chan_dac_shift_out[2*c +: 2] <= dac_shift(
               channel_function_reg_ff[c][C_SCALE_HI:C_SCALE_LO]);
   end

   // power-down decode, one means low power
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         chan_digital_pd_out     <= 2'h0;
         chan_dac_digital_pd_out <= 2'h0;
         chan_dac_analog_pd_out  <= 2'h0;
         clk_input_pd_out        <= 1'b0;
         pll_pd_out              <= 1'b0;
         osc_pd_out              <= 1'b0;
         serial_single_bit_out   <= 1'b0;
      end
      else
      begin
         logic       full;
         logic [4:0] mult;
         full = pd_sync && global_function_reg_ff[G_EXT_PD_FULL];
         mult = global_function_reg_ff[G_PLL_MULT_HI:G_PLL_MULT_LO];
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (pd_sync)
            begin
               chan_digital_pd_out[c]     <= 1'b1;
               chan_dac_digital_pd_out[c] <= 1'b1;
               chan_dac_analog_pd_out[c]  <= full;
            end
            else
            begin
               chan_digital_pd_out[c] <=
                  channel_function_reg_ff[c][C_DIGITAL_PD];
               chan_dac_digital_pd_out[c] <=
                  channel_function_reg_ff[c][C_DAC_PD];
               chan_dac_analog_pd_out[c] <=
                  channel_function_reg_ff[c][C_DAC_PD];
            end
         end
         clk_input_pd_out <= pd_sync ? full
                             : global_function_reg_ff[G_CLKIN_PD];
         pll_pd_out <= full || mult < PLL_MULT_MIN ||
                       mult > PLL_MULT_MAX;
         osc_pd_out <= full;
         serial_single_bit_out <=
            global_function_reg_ff[G_RAMP_HI:G_RAMP_LO] == RAMP_SERIAL;
      end
   end
endmodule : dpm_ctl

// ==== inc/dpm_pkg.sv ====
// shared constants for the profile modulation and power control block
package dpm_pkg;
   // register offsets
   localparam logic [4:0] OFS_GLOBAL_FUNC  = 5'h01;
   localparam logic [4:0] OFS_CHAN_FUNC    = 5'h03;
   localparam logic [4:0] OFS_FREQ_WORD0   = 5'h04;
   localparam logic [4:0] OFS_PHASE_WORD0  = 5'h05;
   localparam logic [4:0] OFS_AMPL_WORD0   = 5'h06;
   localparam logic [4:0] OFS_PROFILE_1    = 5'h0A;
   localparam logic [4:0] OFS_PROFILE_15   = 5'h18;
   // widths
   localparam int FUNC_W  = 24;
   localparam int FREQ_W  = 32;
   localparam int PHASE_W = 14;
   localparam int AMPL_W  = 10;
   localparam int NUM_CH  = 2;
   // reset values
   localparam logic [23:0] GLOBAL_FUNC_RST = 24'h000000;
   localparam logic [23:0] CHAN_FUNC_RST   = 24'h000300;
   // global function register fields
   localparam int G_PLL_MULT_HI = 22;
   localparam int G_PLL_MULT_LO = 18;
   localparam int G_PPC_HI      = 14;
   localparam int G_PPC_LO      = 12;
   localparam int G_RAMP_HI     = 11;
   localparam int G_RAMP_LO     = 10;
   localparam int G_LEVEL_HI    = 9;
   localparam int G_LEVEL_LO    = 8;
   localparam int G_CLKIN_PD    = 7;
   localparam int G_EXT_PD_FULL = 6;
   // channel function register fields
   localparam int C_MOD_HI      = 23;
   localparam int C_MOD_LO      = 22;
   localparam int C_LIN_SWEEP   = 14;
   localparam int C_SCALE_HI    = 9;
   localparam int C_SCALE_LO    = 8;
   localparam int C_DIGITAL_PD  = 7;
   localparam int C_DAC_PD      = 6;
   // pll multiplier bypass limits
   localparam logic [4:0] PLL_MULT_MIN = 5'h04;
   localparam logic [4:0] PLL_MULT_MAX = 5'h14;
   // ppc codes
   localparam logic [2:0] PPC_FOUR_LVL = 3'h5;
   localparam logic [1:0] PPC_SEL_CH0  = 2'h2;
   localparam logic [1:0] PPC_SEL_CH1  = 2'h3;

   typedef enum logic [1:0] {
      MOD_NONE  = 2'h0,
      MOD_AMPL  = 2'h1,
      MOD_FREQ  = 2'h2,
      MOD_PHASE = 2'h3
   } dpm_mod_type_t;

   typedef enum logic [1:0] {
      LVL_TWO     = 2'h0,
      LVL_FOUR    = 2'h1,
      LVL_EIGHT   = 2'h2,
      LVL_SIXTEEN = 2'h3
   } dpm_mod_level_t;

   typedef enum logic [1:0] {
      RAMP_OFF      = 2'h0,
      RAMP_PINS_23  = 2'h1,
      RAMP_PIN_3    = 2'h2,
      RAMP_SERIAL   = 2'h3
   } dpm_ramp_sel_t;
endpackage : dpm_pkg

// ==== rtl/dpm_pin_sync.sv ====
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module dpm_pin_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] pins_in,
   output logic      [WIDTH-1:0] pins_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= pins_in;
         sync_ff <= meta_ff;
      end
   end

   assign pins_out = sync_ff;
endmodule : dpm_pin_sync

// ==== verification/dpm_ctl_sva.sv ====
// concurrent checks on the ports of the modulation and power control block
`timescale 1ns/1ps
module dpm_ctl_sva
   import dpm_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic        reg_wr_in,
   input wire logic [4:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [1:0]  reg_chan_en_in,
   input wire logic [3:0]  profile_pin_in,
   input wire logic        ext_powerdown_pin_in,
   input wire logic [1:0]  ramp_serial_in,
   input wire logic [1:0]  chan_ramp_en_out,
   input wire logic [1:0]  chan_ramp_down_out,
   input wire logic [3:0]  chan_dac_shift_out,
   input wire logic [1:0]  chan_digital_pd_out,
   input wire logic [1:0]  chan_dac_digital_pd_out,
   input wire logic [1:0]  chan_dac_analog_pd_out,
   input wire logic        clk_input_pd_out,
   input wire logic        pll_pd_out,
   input wire logic        osc_pd_out,
   input wire logic        serial_single_bit_out
);
   logic [23:0] g_ff, c0_ff, c1_ff;
   logic [3:0]  q_ff;
   logic        qt, byp, cw;
   assign qt = q_ff > 4'h7;
   assign cw = reg_wr_in && reg_addr_in == OFS_CHAN_FUNC;
   assign byp = g_ff[22:18] < PLL_MULT_MIN || g_ff[22:18] > PLL_MULT_MAX;
   // cycles since reset or the last register write
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in) q_ff <= 4'h0;
      else if (reg_wr_in) q_ff <= 4'h0;
      else if (q_ff != 4'hF) q_ff <= q_ff + 4'h1;
   // shadow of the function registers
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in) g_ff <= GLOBAL_FUNC_RST;
      else if (reg_wr_in && reg_addr_in == OFS_GLOBAL_FUNC)
         g_ff <= reg_wdata_in[23:0];
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in) c0_ff <= CHAN_FUNC_RST;
      else if (cw && reg_chan_en_in[0]) c0_ff <= reg_wdata_in[23:0];
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in) c1_ff <= CHAN_FUNC_RST;
      else if (cw && reg_chan_en_in[1]) c1_ff <= reg_wdata_in[23:0];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   a_dac_scale_code: assert property (qt |-> chan_dac_shift_out ==
      ~{c1_ff[8], c1_ff[9], c0_ff[8], c0_ff[9]}) else $error("dac scale");
   a_fast_pd_mode: assert property (ext_powerdown_pin_in [*5] ##0
      (qt && !g_ff[6]) |-> {chan_digital_pd_out, chan_dac_digital_pd_out,
      chan_dac_analog_pd_out, clk_input_pd_out, pll_pd_out, osc_pd_out}
      == {6'h3C, 1'b0, byp, 1'b0}) else $error("fast power-down");
   a_full_pd_mode: assert property (ext_powerdown_pin_in [*5] ##0
      (qt && g_ff[6]) |-> {chan_digital_pd_out, chan_dac_digital_pd_out,
      chan_dac_analog_pd_out, clk_input_pd_out, pll_pd_out, osc_pd_out}
      == 9'h1FF) else $error("full power-down");
   a_sw_pd_bits: assert property (!ext_powerdown_pin_in [*5] ##0 qt |->
      chan_digital_pd_out == {c1_ff[7], c0_ff[7]} &&
      chan_dac_digital_pd_out == {c1_ff[6], c0_ff[6]} &&
      chan_dac_analog_pd_out == {c1_ff[6], c0_ff[6]} &&
      clk_input_pd_out == g_ff[7]) else $error("software power-down");
   a_pll_bypass_off: assert property (!ext_powerdown_pin_in [*5] ##0 qt
      |-> pll_pd_out == byp) else $error("pll bypass");
   a_serial_single: assert property (qt |-> serial_single_bit_out ==
      (g_ff[11:10] == RAMP_SERIAL)) else $error("serial single bit");
   a_ramp_no_ampl: assert property (qt && chan_ramp_en_out[0] |->
      c0_ff[23:22] != MOD_AMPL && !c0_ff[14] && g_ff[11:10] != RAMP_OFF)
      else $error("ramp with amplitude");
   a_ramp_pin_dir: assert property ($stable(profile_pin_in) [*6] ##0
      (qt && g_ff[11:10] == RAMP_PINS_23 && chan_ramp_en_out[1]) |->
      chan_ramp_down_out[1] == profile_pin_in[3]) else $error("ramp pin");
   a_ramp_serial_dir: assert property ($stable(ramp_serial_in) [*6] ##0
      (qt && g_ff[11:10] == RAMP_SERIAL && chan_ramp_en_out[0]) |->
      chan_ramp_down_out[0] == ramp_serial_in[0]) else $error("ramp line");
endmodule : dpm_ctl_sva
bind dpm_ctl dpm_ctl_sva u_sva (.*);

// ==== verification/dpm_host_model.sv ====
// host controller driving profile, power-down and serial ramp pins
`timescale 1ns/1ps
module dpm_host_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] pin_req_in,
   input  wire logic       pd_req_in,
   input  wire logic [1:0] ser_req_in,
   output logic      [3:0] profile_pin_out,
   output logic            ext_powerdown_pin_out,
   output logic      [1:0] ramp_serial_out
);
   initial {profile_pin_out, ext_powerdown_pin_out, ramp_serial_out} = '0;
   // request taken at a clock edge, pins move just after it
   always @(posedge clk_in)
   begin
      profile_pin_out       <= #1 pin_req_in;
      ext_powerdown_pin_out <= #1 pd_req_in;
      ramp_serial_out       <= #1 ser_req_in;
   end
endmodule : dpm_host_model

// ==== verification/tb_dds_profile_modulation_power_ctl.sv ====
// self-checking bench for the modulation and power control block
`timescale 1ns/1ps
module tb_dds_profile_modulation_power_ctl import dpm_pkg::*;;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, pd_rq = 0, pd;
   logic [4:0]  addr = '0;
   logic [31:0] wd = '0, rdata, ph0, am0;
   logic [1:0]  en = '0, ser_rq = '0, ser, ren, rdn, dpd, ddpd, dapd, re, mact;
   logic [3:0]  pin_rq = '0, pin, shf;
   logic [63:0] freq;
   logic [27:0] ph;
   logic [19:0] am;
   logic        cpd, ppd, opd, sbit;
   logic [31:0] w [2][16];
   int          fail_count = 0, cmp_count = 0;
   // rows: level, ramp field, pin config, ch0 type, ch1 type
   int cfg [9][5] = '{'{0,0,0,2,2}, '{1,0,5,3,2}, '{2,0,2,1,0},
      '{2,0,3,0,2}, '{3,0,2,3,0}, '{3,0,7,0,3}, '{0,1,5,1,2},
      '{2,2,6,2,0}, '{0,3,0,2,3}};
   always #2 clk = ~clk;
   dpm_host_model u_host (.clk_in(clk), .pin_req_in(pin_rq),
      .pd_req_in(pd_rq), .ser_req_in(ser_rq), .profile_pin_out(pin),
      .ext_powerdown_pin_out(pd), .ramp_serial_out(ser));
   dpm_ctl u_dut (.clk_in(clk), .reset_n_in(rst_n), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd),
      .reg_chan_en_in(en), .profile_pin_in(pin),
      .ext_powerdown_pin_in(pd), .ramp_serial_in(ser),
      .reg_rdata_out(rdata), .chan_freq_out(freq), .chan_phase_out(ph),
      .chan_ampl_out(am), .chan_mod_active_out(mact), .chan_ramp_en_out(ren),
      .chan_ramp_down_out(rdn), .chan_dac_shift_out(shf),
      .chan_digital_pd_out(dpd), .chan_dac_digital_pd_out(ddpd),
      .chan_dac_analog_pd_out(dapd), .clk_input_pd_out(cpd),
      .pll_pd_out(ppd), .osc_pd_out(opd), .serial_single_bit_out(sbit));
   task automatic chk(input string n, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic acc(input logic r, input logic [4:0] a,
                      input logic [1:0] c, input logic [31:0] d);
      @(posedge clk);
      #1 {wr, rd, addr, en, wd} = {!r, r, a, c, d};
      @(posedge clk);
      #1 {wr, rd} = 2'h0;
      @(posedge clk);
      #1;
   endtask : acc
   task automatic finish_test();
      $display("compares %0d errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   function automatic logic [31:0] gfr(int mu, profile_pin_config, rmp, lvl);
      return 32'((mu << 18) | (profile_pin_config << 12) | (rmp << 10) | (lvl << 8));
   endfunction : gfr
   // linear sweep kept clear for pin modulation
   function automatic logic [31:0] channel_function_reg(int ty, pb);
      return 32'((ty << 22) | 32'h300 | (pb << 6));
   endfunction : channel_function_reg
   function automatic int exp_idx(int lvl, rmp, profile_pin_config, logic [3:0] p, int ch);
      if (rmp == 1) return ch ? p[1] : p[0];
      case (lvl)
         0: return ch ? p[3] : p[2];
         1: return ch ? {p[2], p[3]} : {p[0], p[1]};
         2: return (profile_pin_config[0] == ch) ? {p[0], p[1], p[2]} : 0;
         default: return (profile_pin_config[0] == ch) ? {p[0], p[1], p[2], p[3]} : 0;
      endcase
   endfunction : exp_idx
   initial
   begin
      #100000;
      fail_count++;
      finish_test();
   end
   initial
   begin
      int i, t, pb, mu;
      logic [8:0] e;
      void'($urandom(32'hc1b14ba7));
      repeat (16) @(posedge clk);
      #1 rst_n = 1;
      acc(1, OFS_CHAN_FUNC, 2'h1, 0);
      chk("chan_func", CHAN_FUNC_RST, rdata);
      acc(1, OFS_GLOBAL_FUNC, 2'h1, 0);
      chk("global_func", GLOBAL_FUNC_RST, rdata);
      acc(0, 5'h1F, 2'h3, $urandom);
      acc(1, 5'h1F, 2'h3, 0);
      chk("unmapped", 0, rdata);
      ph0 = $urandom;
      am0 = $urandom;
      acc(0, OFS_PHASE_WORD0, 2'h3, ph0);
      acc(0, OFS_AMPL_WORD0, 2'h3, am0);
      acc(1, OFS_PHASE_WORD0, 2'h1, 0);
      chk("phase_word0", ph0[13:0], rdata);
      acc(1, OFS_AMPL_WORD0, 2'h2, 0);
      chk("ampl_word0", am0[9:0], rdata);
      for (int s = 0; s < 4; s++)
      begin
         acc(0, OFS_CHAN_FUNC, 2'h1, 32'(s << 8));
         chk("dac_shift", {2'h0, ~s[0], ~s[1]}, shf);
         repeat (7) @(posedge clk);
      end
      for (int k = 0; k < 4; k++)
      begin
         pb = $urandom_range(3);
         mu = (k == 2) ? 30 : 4 * k + 4;
         acc(0, OFS_CHAN_FUNC, 2'h2, channel_function_reg(0, pb));
         acc(0, OFS_GLOBAL_FUNC, 2'h1, gfr(mu, 0, 0, 0) | 32'((k % 2) << 6) | 32'h80);
         pd_rq = k[1];
         repeat (9) @(posedge clk);
         #1;
         if (!k[1]) e = {pb[1], 1'b0, pb[0], 1'b0, pb[0], 1'b0, 1'b1, 1'(mu < 4 || mu > 20), 1'b0};
         else if (!k[0]) e = {6'h3C, 1'b0, 1'(mu > 20), 1'b0};
         else e = 9'h1FF;
         chk("power_down", e, {dpd, ddpd, dapd, cpd, ppd, opd});
      end
      pd_rq = 0;
      for (int k = 0; k < 32; k++)
      begin
         w[k / 16][k % 16] = $urandom;
         acc(0, (k % 16) ? 5'(OFS_PROFILE_1 + k % 16 - 1) : OFS_FREQ_WORD0,
             2'(1 << (k / 16)), w[k / 16][k % 16]);
      end
      foreach (cfg[r])
      begin
         acc(0, OFS_GLOBAL_FUNC, 2'h1, gfr(10, cfg[r][2], cfg[r][1], cfg[r][0]));
         acc(0, OFS_CHAN_FUNC, 2'h1, channel_function_reg(cfg[r][3], 0));
         acc(0, OFS_CHAN_FUNC, 2'h2, channel_function_reg(cfg[r][4], 0));
         re = (cfg[r][1] == 2) ? 2'h1 : (cfg[r][1] == 0) ? 2'h0 : {cfg[r][4] != 1, cfg[r][3] != 1};
         for (int n = 0; n < 10; n++)
         begin
            pin_rq = (n == 0) ? 4'hF : (n == 1) ? 4'h0 : 4'($urandom);
            ser_rq = 2'($urandom);
            repeat (7) @(posedge clk);
            #1;
            for (int ch = 0; ch < 2; ch++)
            begin
               i = exp_idx(cfg[r][0], cfg[r][1], cfg[r][2], pin_rq, ch);
               t = cfg[r][3 + ch];
               chk("freq", (t == 2 && i > 0) ? w[ch][i] : w[ch][0], freq[32 * ch +: 32]);
               chk("phase", (t == 3 && i > 0) ? w[ch][i][31:18] : ph0[13:0], ph[14 * ch +: 14]);
               chk("ampl", (t == 1 && i > 0) ? w[ch][i][31:22] : am0[9:0], am[10 * ch +: 10]);
            end
            chk("ramp_en", re, ren);
            chk("mod_active", {cfg[r][4] != 0, cfg[r][3] != 0}, mact);
            chk("ramp_dn", re & ((cfg[r][1] == 3) ? ser_rq : (cfg[r][1] == 2) ? {1'b0, pin_rq[3]} : pin_rq[3:2]), re & rdn);
            chk("single_bit", cfg[r][1] == 3, sbit);
         end
      end
      finish_test();
   end
endmodule : tb_dds_profile_modulation_power_ctl
